// ==== shared/cssu_pkg.sv ====
// constants, encodings and state type for the clock source select and start-up block
// Function
// - decode four-bit source code, reserved odd codes below eight
// - fuse bit zero means programmed, one unprogrammed
// - wake from power-down waits selected-source delay
// - reset adds delay counted on watchdog oscillator
// - reset time-out is none, 4K or 64K cycles
// - shipped: code 0010, start-up 10, div8 programmed
// - default configuration prescales source clock by eight
// - core clock feeds registers, status and stack
// - separate peripheral clock for timers, serial, interrupts
// - some external interrupts detected without peripheral clock
// - serial port start detected while peripheral clock stopped
// - program-memory clock runs together with core clock
// - unused clocks gated off by sleep mode
// - divide-by-eight fuse divides oscillator once start-up ends; start-up counts run undivided
// - RC source: 6-cycle wake, 14 plus reset delay
package cssu_pkg;
    localparam logic [3:0] CSSU_SEL_EXT = 4'h0;
    localparam logic [3:0] CSSU_SEL_RC4 = 4'h2;
    localparam logic [3:0] CSSU_SEL_RC8 = 4'h4;
    localparam logic [3:0] CSSU_SEL_WDOSC = 4'h6;
    localparam int CSSU_SEL_XTAL_BIT = 3;
    localparam int CSSU_SEL_RSVD_BIT = 0;
    localparam logic [3:0] CSSU_SHIP_SEL = 4'h2;
    localparam logic [1:0] CSSU_SHIP_SUT = 2'h2;
    localparam logic CSSU_SHIP_DIV8 = 1'b0;
    localparam logic CSSU_FUSE_PROGRAMMED = 1'b0;
    localparam logic [1:0] CSSU_SUT_NONE = 2'h0;
    localparam logic [1:0] CSSU_SUT_SHORT = 2'h1;
    localparam logic [1:0] CSSU_SUT_LONG = 2'h2;
    // one-hot source selections
    localparam logic [4:0] CSSU_SRC_EXT = 5'h01;
    localparam logic [4:0] CSSU_SRC_RC4 = 5'h02;
    localparam logic [4:0] CSSU_SRC_RC8 = 5'h04;
    localparam logic [4:0] CSSU_SRC_WDOSC = 5'h08;
    localparam logic [4:0] CSSU_SRC_XTAL = 5'h10;
    // sleep modes
    localparam logic [1:0] CSSU_SLP_IDLE = 2'h0;
    localparam logic [1:0] CSSU_SLP_PDOWN = 2'h1;
    localparam logic [1:0] CSSU_SLP_STANDBY = 2'h2;
    // counts, in cycles of the clock named beside each
    localparam int CSSU_CNT_W = 17;
    localparam int CSSU_FUSE_SETTLE = 3;
    localparam int CSSU_RST_SRC_CYCLES = 14;
    localparam int CSSU_RC_WAKE_CYCLES = 6;
    localparam int CSSU_WDT_SHORT_CYCLES = 4096;
    localparam int CSSU_WDT_LONG_CYCLES = 65536;
    localparam int CSSU_XTAL_WAKE_FAST = 258;
    localparam int CSSU_XTAL_WAKE_MED = 1024;
    localparam int CSSU_XTAL_WAKE_SLOW = 16384;
    localparam int CSSU_DIV8_LAST = 7;
    // synchroniser bit positions
    localparam int CSSU_SY_EXT = 0;
    localparam int CSSU_SY_XTAL = 1;
    localparam int CSSU_SY_RC8 = 2;
    localparam int CSSU_SY_WDOSC = 3;
    localparam int CSSU_SY_INT_N = 4;
    localparam int CSSU_SY_SDA = 5;
    localparam int CSSU_SY_SCL = 6;
    localparam int CSSU_SY_SEL_LO = 7;
    localparam int CSSU_SY_SEL_HI = 10;
    localparam int CSSU_SY_SUT_LO = 11;
    localparam int CSSU_SY_SUT_HI = 12;
    localparam int CSSU_SY_DIV8 = 13;
    localparam int CSSU_SY_W = 14;

    typedef enum logic [5:0] {
        CSSU_ST_FUSE = 6'h01,
        CSSU_ST_RST_SRC = 6'h02,
        CSSU_ST_RST_WDT = 6'h04,
        CSSU_ST_RUN = 6'h08,
        CSSU_ST_SLEEP = 6'h10,
        CSSU_ST_WAKE = 6'h20
    } cssu_state_e;
endpackage

// ==== src/cssu_clock_control.sv ====
// clock source select, start-up timing and clock gating
`timescale 1ns/1ps
module cssu_clock_control #(
    parameter int P_WDT_LONG_CYCLES = cssu_pkg::CSSU_WDT_LONG_CYCLES,
    parameter int P_XTAL_WAKE_SLOW = cssu_pkg::CSSU_XTAL_WAKE_SLOW
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [3:0] i_clock_source_select_fuses,
    input wire logic [1:0] i_startup_delay_fuses,
    input wire logic i_divide_by_eight_fuse,
    input wire logic i_ext_clock_pin,
    input wire logic i_xtal_osc,
    input wire logic i_rc_osc,
    input wire logic i_supervisory_timer_osc,
    input wire logic i_ext_int_n,
    input wire logic i_usp_sda,
    input wire logic i_usp_scl,
    input wire logic i_sleep_req,
    input wire logic [1:0] i_sleep_mode,
    input wire logic i_wake,
    output logic o_core_clock_en,
    output logic o_periph_clock_en,
    output logic o_flash_clock_en,
    output logic o_cpu_run,
    output logic o_startup_busy,
    output logic [4:0] o_source,
    output logic o_source_invalid,
    output logic o_ext_int_wake,
    output logic o_usp_start
);
    localparam int W = cssu_pkg::CSSU_CNT_W;

    logic [cssu_pkg::CSSU_SY_W-1:0] sync1;
    logic [cssu_pkg::CSSU_SY_W-1:0] sync2;
    logic [cssu_pkg::CSSU_SY_W-1:0] prev;
    logic [cssu_pkg::CSSU_SY_W-1:0] rise;
    logic [3:0] raw_sel;
    logic raw_valid;
    logic [4:0] dec_src;
    logic [4:0] next_src;
    logic [3:0] sel_code;
    logic [1:0] startup_delay_fuses;
    logic div8_on;
    logic [4:0] src;
    logic invalid;
    logic rc_half;
    logic rc4_tick;
    logic src_tick;
    logic sys_tick;
    logic wdt_rise;
    logic ext_int_low;
    logic usp_start;
    logic wake_any;
    logic [1:0] mode;
    logic core_on;
    logic periph_on;
    logic [W-1:0] cnt;
    logic [W-1:0] wdt_count;
    logic [W-1:0] wake_count;
    logic cnt_done_src;
    logic cnt_done_wdt;
    logic cnt_done_wake;
    cssu_pkg::cssu_state_e state;
    cssu_pkg::cssu_state_e next_state;

    // reset time-out on the watchdog oscillator; reserved code takes the longest
    function automatic logic [W-1:0] reset_wdt_cycles(input logic [1:0] s);
        logic [W-1:0] r;
        r = W'(P_WDT_LONG_CYCLES);
        if (s == cssu_pkg::CSSU_SUT_NONE) begin
            r = '0;
        end else if (s == cssu_pkg::CSSU_SUT_SHORT) begin
            r = W'(cssu_pkg::CSSU_WDT_SHORT_CYCLES);
        end
        return r;
    endfunction

    // wake delay in source cycles; crystal uses its low code bit with the start-up code
    function automatic logic [W-1:0] wake_cycles(input logic [3:0] c, input logic [1:0] s);
        logic [2:0] k;
        logic [W-1:0] r;
        k = {c[0], s};
        r = W'(cssu_pkg::CSSU_RC_WAKE_CYCLES);
        if (c[cssu_pkg::CSSU_SEL_XTAL_BIT]) begin
            if (k <= 3'h1) begin
                r = W'(cssu_pkg::CSSU_XTAL_WAKE_FAST);
            end else if (k <= 3'h4) begin
                r = W'(cssu_pkg::CSSU_XTAL_WAKE_MED);
            end else begin
                r = W'(P_XTAL_WAKE_SLOW);
            end
        end
        return r;
    endfunction

    // every pin, fuses included, crosses through two flops
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else begin
            sync1 <= {i_divide_by_eight_fuse, i_startup_delay_fuses, i_clock_source_select_fuses,
                      i_usp_scl, i_usp_sda, i_ext_int_n, i_supervisory_timer_osc, i_rc_osc,
                      i_xtal_osc, i_ext_clock_pin};
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    assign rise = sync2 & ~prev;
    assign raw_sel = sync2[cssu_pkg::CSSU_SY_SEL_HI:cssu_pkg::CSSU_SY_SEL_LO];
    assign raw_valid = raw_sel[cssu_pkg::CSSU_SEL_XTAL_BIT] |
                       !raw_sel[cssu_pkg::CSSU_SEL_RSVD_BIT];
    assign dec_src = raw_sel[cssu_pkg::CSSU_SEL_XTAL_BIT] ? cssu_pkg::CSSU_SRC_XTAL :
                     (raw_sel == cssu_pkg::CSSU_SEL_EXT) ? cssu_pkg::CSSU_SRC_EXT :
                     (raw_sel == cssu_pkg::CSSU_SEL_RC4) ? cssu_pkg::CSSU_SRC_RC4 :
                     (raw_sel == cssu_pkg::CSSU_SEL_RC8) ? cssu_pkg::CSSU_SRC_RC8 :
                     cssu_pkg::CSSU_SRC_WDOSC;
    // a reserved code never drives the clock; the shipped 4 MHz source stands in
    assign next_src = raw_valid ? dec_src : cssu_pkg::CSSU_SRC_RC4;

    assign rc4_tick = rise[cssu_pkg::CSSU_SY_RC8] & rc_half;
    assign wdt_rise = rise[cssu_pkg::CSSU_SY_WDOSC];
    assign src_tick = |(src & {rise[cssu_pkg::CSSU_SY_XTAL], wdt_rise,
                               rise[cssu_pkg::CSSU_SY_RC8], rc4_tick,
                               rise[cssu_pkg::CSSU_SY_EXT]});
    // detection runs off the raw pin path, not the gated peripheral clock
    assign ext_int_low = !sync2[cssu_pkg::CSSU_SY_INT_N];
    assign usp_start = prev[cssu_pkg::CSSU_SY_SDA] & !sync2[cssu_pkg::CSSU_SY_SDA] &
                       sync2[cssu_pkg::CSSU_SY_SCL];
    assign wake_any = i_wake | ext_int_low | usp_start;

    assign wdt_count = reset_wdt_cycles(startup_delay_fuses);
    assign wake_count = wake_cycles(sel_code, startup_delay_fuses);
    assign cnt_done_src = src_tick && (cnt == W'(cssu_pkg::CSSU_RST_SRC_CYCLES - 1));
    assign cnt_done_wdt = wdt_rise && (cnt == W'(wdt_count - W'(1)));
    assign cnt_done_wake = src_tick && (cnt == W'(wake_count - W'(1)));

    assign core_on = (state == cssu_pkg::CSSU_ST_RUN);
    assign periph_on = core_on ||
                       (state == cssu_pkg::CSSU_ST_SLEEP && mode == cssu_pkg::CSSU_SLP_IDLE);

    cssu_divider u_prescale (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_tick(src_tick),
        .i_div8(div8_on),
        .o_tick(sys_tick)
    );

    always_comb begin
        next_state = state;
        case (state)
            cssu_pkg::CSSU_ST_FUSE: begin
                if (cnt == W'(cssu_pkg::CSSU_FUSE_SETTLE - 1)) begin
                    next_state = cssu_pkg::CSSU_ST_RST_SRC;
                end
            end
            cssu_pkg::CSSU_ST_RST_SRC: begin
                if (cnt_done_src) begin
                    next_state = (wdt_count == '0) ? cssu_pkg::CSSU_ST_RUN :
                                 cssu_pkg::CSSU_ST_RST_WDT;
                end
            end
            cssu_pkg::CSSU_ST_RST_WDT: begin
                if (cnt_done_wdt) begin
                    next_state = cssu_pkg::CSSU_ST_RUN;
                end
            end
            cssu_pkg::CSSU_ST_RUN: begin
                if (i_sleep_req) begin
                    next_state = cssu_pkg::CSSU_ST_SLEEP;
                end
            end
            cssu_pkg::CSSU_ST_SLEEP: begin
                if (wake_any) begin
                    // only power-down stops the oscillator, so only it pays the delay
                    next_state = (mode == cssu_pkg::CSSU_SLP_PDOWN) ? cssu_pkg::CSSU_ST_WAKE :
                                 cssu_pkg::CSSU_ST_RUN;
                end
            end
            cssu_pkg::CSSU_ST_WAKE: begin
                if (cnt_done_wake) begin
                    next_state = cssu_pkg::CSSU_ST_RUN;
                end
            end
            default: begin
                next_state = cssu_pkg::CSSU_ST_FUSE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= cssu_pkg::CSSU_ST_FUSE;
            cnt <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                cnt <= '0;
            end else if (state == cssu_pkg::CSSU_ST_FUSE) begin
                cnt <= cnt + W'(1);
            end else if (state == cssu_pkg::CSSU_ST_RST_WDT) begin
                cnt <= cnt + W'(wdt_rise);
            end else if (state inside {cssu_pkg::CSSU_ST_RST_SRC, cssu_pkg::CSSU_ST_WAKE}) begin
                cnt <= cnt + W'(src_tick);
            end
        end
    end

    // settings are caught once per reset, after the synchronisers have filled
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sel_code <= cssu_pkg::CSSU_SHIP_SEL;
            startup_delay_fuses <= cssu_pkg::CSSU_SHIP_SUT;
            div8_on <= 1'b1;
            src <= cssu_pkg::CSSU_SRC_RC4;
            invalid <= 1'b0;
        end else if (state == cssu_pkg::CSSU_ST_FUSE && next_state != state) begin
            sel_code <= raw_sel;
            startup_delay_fuses <= sync2[cssu_pkg::CSSU_SY_SUT_HI:cssu_pkg::CSSU_SY_SUT_LO];
            div8_on <= sync2[cssu_pkg::CSSU_SY_DIV8] == cssu_pkg::CSSU_FUSE_PROGRAMMED;
            src <= next_src;
            invalid <= !raw_valid;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rc_half <= 1'b0;
            mode <= cssu_pkg::CSSU_SLP_IDLE;
        end else begin
            if (rise[cssu_pkg::CSSU_SY_RC8]) begin
                rc_half <= !rc_half;
            end
            if (state == cssu_pkg::CSSU_ST_RUN && i_sleep_req) begin
                mode <= i_sleep_mode;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_core_clock_en <= 1'b0;
            o_periph_clock_en <= 1'b0;
            o_flash_clock_en <= 1'b0;
            o_cpu_run <= 1'b0;
            o_startup_busy <= 1'b1;
            o_source <= cssu_pkg::CSSU_SRC_RC4;
            o_source_invalid <= 1'b0;
            o_ext_int_wake <= 1'b0;
            o_usp_start <= 1'b0;
        end else begin
            o_core_clock_en <= core_on & sys_tick;
            o_periph_clock_en <= periph_on & sys_tick;
            o_flash_clock_en <= core_on & sys_tick;
            o_cpu_run <= core_on;
            o_startup_busy <= (state != cssu_pkg::CSSU_ST_RUN && state != cssu_pkg::CSSU_ST_SLEEP);
            o_source <= src;
            o_source_invalid <= invalid;
            o_ext_int_wake <= ext_int_low & (state == cssu_pkg::CSSU_ST_SLEEP);
            o_usp_start <= usp_start;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    property p_xtal_decode;
        (state != cssu_pkg::CSSU_ST_FUSE && sel_code[cssu_pkg::CSSU_SEL_XTAL_BIT])
            |-> src == cssu_pkg::CSSU_SRC_XTAL;
    endproperty
    a_xtal_decode: assert property (p_xtal_decode) else $error("crystal not decoded");
    property p_div8_inverted;
        $fell(state == cssu_pkg::CSSU_ST_FUSE) |-> div8_on != $past(sync2[cssu_pkg::CSSU_SY_DIV8]);
    endproperty
    a_div8_inverted: assert property (p_div8_inverted) else $error("fuse sense wrong");
    property p_wake_gated;
        (state == cssu_pkg::CSSU_ST_WAKE) |=> !o_core_clock_en;
    endproperty
    a_wake_gated: assert property (p_wake_gated) else $error("core clock in wake");
    property p_reset_on_wdt;
        ($rose(state == cssu_pkg::CSSU_ST_RUN) && $past(state == cssu_pkg::CSSU_ST_RST_WDT))
            |-> $past(wdt_rise);
    endproperty
    a_reset_on_wdt: assert property (p_reset_on_wdt) else $error("delay not on wdt");
    property p_wdt_bound;
        (state == cssu_pkg::CSSU_ST_RST_WDT) |-> cnt < wdt_count;
    endproperty
    a_wdt_bound: assert property (p_wdt_bound) else $error("reset time-out overran");
    property p_prescale;
        (sys_tick && div8_on) |=> !sys_tick [*7];
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescale below eight");
    property p_core_run;
        o_core_clock_en |-> $past(state == cssu_pkg::CSSU_ST_RUN);
    endproperty
    a_core_run: assert property (p_core_run) else $error("core clock outside run");
    property p_idle_periph;
        (state == cssu_pkg::CSSU_ST_SLEEP && mode == cssu_pkg::CSSU_SLP_IDLE && sys_tick)
            |=> o_periph_clock_en && !o_core_clock_en;
    endproperty
    a_idle_periph: assert property (p_idle_periph) else $error("idle gating wrong");
    property p_int_wakes;
        (state == cssu_pkg::CSSU_ST_SLEEP && ext_int_low) |=> state != cssu_pkg::CSSU_ST_SLEEP;
    endproperty
    a_int_wakes: assert property (p_int_wakes) else $error("interrupt missed in sleep");
    property p_usp_start;
        usp_start |=> o_usp_start;
    endproperty
    a_usp_start: assert property (p_usp_start) else $error("start condition lost");
    property p_flash_core;
        o_flash_clock_en == o_core_clock_en;
    endproperty
    a_flash_core: assert property (p_flash_core) else $error("flash clock apart");
    property p_settings_fixed;
        (state != cssu_pkg::CSSU_ST_FUSE && $past(state != cssu_pkg::CSSU_ST_FUSE))
            |-> $stable(sel_code) && $stable(startup_delay_fuses) && $stable(src);
    endproperty
    a_settings_fixed: assert property (p_settings_fixed) else $error("settings moved");
    property p_fallback;
        invalid |-> src == cssu_pkg::CSSU_SRC_RC4;
    endproperty
    a_fallback: assert property (p_fallback) else $error("reserved code used");

    c_run: cover property ($rose(state == cssu_pkg::CSSU_ST_RUN));
    c_pdown_wake: cover property ($fell(state == cssu_pkg::CSSU_ST_WAKE));
    c_idle: cover property (state == cssu_pkg::CSSU_ST_SLEEP && o_periph_clock_en);
    c_usp: cover property (o_usp_start && state == cssu_pkg::CSSU_ST_SLEEP);
endmodule // cssu_clock_control

// ==== src/cssu_divider.sv ====
// system clock prescaler: passes every source tick or every eighth one
`timescale 1ns/1ps
module cssu_divider (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_div8,
    output logic o_tick
);
    logic [2:0] phase;
    logic last_phase;

    assign last_phase = (phase == 3'(cssu_pkg::CSSU_DIV8_LAST));

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            phase <= 3'h0;
            o_tick <= 1'b0;
        end else begin
            if (i_tick) begin
                phase <= phase + 3'h1;
            end
            // phase starts at zero so the first output comes on the eighth tick
            o_tick <= i_tick & (!i_div8 | last_phase);
        end
    end
endmodule // cssu_divider

// ==== tb/cssu_osc_model.sv ====
// oscillator and external clock sources facing the clock control block
`timescale 1ns/1ps
module cssu_osc_model (
    input wire logic i_wdt_en,
    output logic o_ext_clock_pin,
    output logic o_xtal_osc,
    output logic o_rc_osc,
    output logic o_supervisory_timer_osc
);
    // half periods are multiples of 5 ns, never on a rising system edge
    initial begin
        o_ext_clock_pin = 1'b0;
        o_xtal_osc = 1'b0;
        o_rc_osc = 1'b0;
        o_supervisory_timer_osc = 1'b0;
    end
    always #15 o_ext_clock_pin = ~o_ext_clock_pin;
    always #20 o_xtal_osc = ~o_xtal_osc;
    always #10 o_rc_osc = ~o_rc_osc;
    // watchdog source far faster than real so time-outs stay short; stops low
    always #10 o_supervisory_timer_osc = i_wdt_en ? ~o_supervisory_timer_osc : 1'b0;
endmodule // cssu_osc_model

// ==== tb/test_cssu_clock_control.sv ====
// self-checking bench for the clock source select and start-up block
`timescale 1ns/1ps
module test_cssu_clock_control;
    logic i_clock, i_rst, fuse_div8, ext_pin, xtal, rc, wosc, int_n, sda, scl;
    logic slp_req, wake, wdt_en, core_en, periph_en, flash_en, cpu_run, busy;
    logic invalid, int_wake, usp_start;
    logic [3:0] fuse_sel;
    logic [1:0] fuse_sut, slp_mode;
    logic [4:0] src;
    int error_cnt, checks;

    cssu_osc_model osc (.i_wdt_en(wdt_en), .o_ext_clock_pin(ext_pin), .o_xtal_osc(xtal),
        .o_rc_osc(rc), .o_supervisory_timer_osc(wosc));
    // long time-outs cut to 20 watchdog rises
    cssu_clock_control #(.P_WDT_LONG_CYCLES(20), .P_XTAL_WAKE_SLOW(20)) DUT (
        .i_clock(i_clock), .i_rst(i_rst), .i_clock_source_select_fuses(fuse_sel),
        .i_startup_delay_fuses(fuse_sut), .i_divide_by_eight_fuse(fuse_div8),
        .i_ext_clock_pin(ext_pin), .i_xtal_osc(xtal), .i_rc_osc(rc),
        .i_supervisory_timer_osc(wosc), .i_ext_int_n(int_n), .i_usp_sda(sda),
        .i_usp_scl(scl), .i_sleep_req(slp_req), .i_sleep_mode(slp_mode), .i_wake(wake),
        .o_core_clock_en(core_en), .o_periph_clock_en(periph_en),
        .o_flash_clock_en(flash_en), .o_cpu_run(cpu_run), .o_startup_busy(busy),
        .o_source(src), .o_source_invalid(invalid), .o_ext_int_wake(int_wake),
        .o_usp_start(usp_start));

    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fail_wait;
        error_cnt++;
        $display("Error at %0t: wait ran out", $time);
        give_verdict();
    endtask

    task automatic start(input logic [3:0] s, input logic [1:0] t, input logic d);
        fuse_sel <= s;
        fuse_sut <= t;
        fuse_div8 <= d;
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        @(posedge i_clock);
    endtask

    task automatic wait_run(input int bound);
        int n;
        n = 0;
        while (cpu_run !== 1'b1) begin
            if (n == bound) fail_wait();
            n++;
            @(posedge i_clock);
        end
    endtask

    // cycles from one core pulse to the next
    task automatic gap(output int g);
        int n;
        n = 0;
        while (core_en !== 1'b1) begin
            if (n == 300) fail_wait();
            n++;
            @(posedge i_clock);
        end
        check(flash_en, core_en);
        @(posedge i_clock);
        g = 1;
        while (core_en !== 1'b1 && g < 300) begin
            g++;
            @(posedge i_clock);
        end
        if (g == 300) fail_wait();
    endtask

    task automatic t_shipped;
        int g;
        start(cssu_pkg::CSSU_SHIP_SEL, cssu_pkg::CSSU_SHIP_SUT, cssu_pkg::CSSU_SHIP_DIV8);
        check(busy, 1'b1);
        wait_run(2000);
        check(src, cssu_pkg::CSSU_SRC_RC4);
        check(busy, 1'b0);
        // RC4 tick is every second rc rise, 8 cycles; divided by eight
        gap(g);
        check(g[7:0], 8'h40);
        check(g[7:0], 8'h40);
    endtask

    task automatic t_decode;
        logic [4:0] e;
        int g;
        for (int c = 0; c < 16; c++) begin
            start(c[3:0], cssu_pkg::CSSU_SUT_NONE, 1'b1);
            wait_run(600);
            e = c[3] ? cssu_pkg::CSSU_SRC_XTAL : c[0] ? cssu_pkg::CSSU_SRC_RC4 :
                c[2:1] == 2'h0 ? cssu_pkg::CSSU_SRC_EXT : c[2:1] == 2'h1 ?
                cssu_pkg::CSSU_SRC_RC4 : c[2:1] == 2'h2 ? cssu_pkg::CSSU_SRC_RC8 :
                cssu_pkg::CSSU_SRC_WDOSC;
            check(src, e);
            check(invalid, c[0] & ~c[3]);
            if (c == 2) begin
                // fuse value one leaves the divider unprogrammed
                gap(g);
                check(g[7:0], 8'h08);
            end
        end
    endtask

    task automatic t_fuse_hold;
        int g;
        start(cssu_pkg::CSSU_SEL_RC8, cssu_pkg::CSSU_SUT_NONE, 1'b1);
        wait_run(400);
        fuse_sel <= cssu_pkg::CSSU_SEL_WDOSC;
        fuse_div8 <= 1'b0;
        repeat (10) @(posedge i_clock);
        check(src, cssu_pkg::CSSU_SRC_RC8);
        gap(g);
        check(g[7:0], 8'h04);
        fuse_sel <= cssu_pkg::CSSU_SEL_RC8;
        fuse_div8 <= 1'b1;
    endtask

    task automatic t_wdt_clock;
        wdt_en <= 1'b0;
        start(cssu_pkg::CSSU_SEL_RC4, cssu_pkg::CSSU_SUT_LONG, 1'b1);
        repeat (600) @(posedge i_clock);
        check(busy, 1'b1);
        check(cpu_run, 1'b0);
        wdt_en <= 1'b1;
        wait_run(300);
    endtask

    task automatic go_sleep(input logic [1:0] m);
        slp_mode <= m;
        slp_req <= 1'b1;
        @(posedge i_clock);
        slp_req <= 1'b0;
        repeat (3) @(posedge i_clock);
        check(cpu_run, 1'b0);
    endtask

    task automatic t_sleep(input logic [1:0] m);
        int nc, np;
        start(cssu_pkg::CSSU_SEL_RC8, cssu_pkg::CSSU_SUT_NONE, 1'b1);
        wait_run(400);
        go_sleep(m);
        nc = 0;
        np = 0;
        repeat (40) begin
            @(posedge i_clock);
            nc += int'(core_en === 1'b1);
            np += int'(periph_en === 1'b1);
        end
        check(nc != 0, 1'b0);
        check(np != 0, m == cssu_pkg::CSSU_SLP_IDLE);
        wake <= 1'b1;
        @(posedge i_clock);
        wake <= 1'b0;
        if (m == cssu_pkg::CSSU_SLP_PDOWN) begin
            // six RC8 ticks at 4 cycles each must pass first
            repeat (10) @(posedge i_clock);
            check(busy, 1'b1);
            check(cpu_run, 1'b0);
            wait_run(60);
        end else
            wait_run(4);
    endtask

    task automatic t_async;
        int n;
        go_sleep(cssu_pkg::CSSU_SLP_PDOWN);
        int_n <= 1'b0;
        // wake flag stands one cycle, the first cycle of the wake state
        repeat (4) @(posedge i_clock);
        check(int_wake, 1'b1);
        int_n <= 1'b1;
        wait_run(60);
        go_sleep(cssu_pkg::CSSU_SLP_PDOWN);
        sda <= 1'b0;
        n = 0;
        while (usp_start !== 1'b1 && n < 8) begin
            n++;
            @(posedge i_clock);
        end
        if (n == 8) fail_wait();
        check(usp_start, 1'b1);
        sda <= 1'b1;
        wait_run(60);
    endtask

    // short reset time-out, then the slowest crystal wake from power-down
    task automatic t_xtal;
        start(4'hf, cssu_pkg::CSSU_SUT_SHORT, 1'b1);
        // 14 crystal ticks plus 4096 watchdog rises of 4 cycles each
        repeat (16300) @(posedge i_clock);
        check(busy, 1'b1);
        check(cpu_run, 1'b0);
        wait_run(600);
        go_sleep(cssu_pkg::CSSU_SLP_PDOWN);
        wake <= 1'b1;
        @(posedge i_clock);
        wake <= 1'b0;
        // 20 crystal ticks of 8 cycles; an RC-length delay would be over by now
        repeat (100) @(posedge i_clock);
        check(busy, 1'b1);
        check(cpu_run, 1'b0);
        wait_run(200);
    endtask

    initial begin
        error_cnt = 0;
        checks = 0;
        i_rst = 1'b1;
        fuse_sel = cssu_pkg::CSSU_SHIP_SEL;
        fuse_sut = cssu_pkg::CSSU_SHIP_SUT;
        fuse_div8 = cssu_pkg::CSSU_SHIP_DIV8;
        int_n = 1'b1;
        sda = 1'b1;
        scl = 1'b1;
        slp_req = 1'b0;
        slp_mode = cssu_pkg::CSSU_SLP_IDLE;
        wake = 1'b0;
        wdt_en = 1'b1;
        t_shipped();
        t_decode();
        t_fuse_hold();
        t_wdt_clock();
        t_sleep(cssu_pkg::CSSU_SLP_IDLE);
        t_sleep(cssu_pkg::CSSU_SLP_STANDBY);
        t_sleep(cssu_pkg::CSSU_SLP_PDOWN);
        t_async();
        t_xtal();
        give_verdict();
    end
endmodule // test_cssu_clock_control
